//--- logic/fault_mgr_defs.svh
/*
  Constants of the LED driver fault manager: register offsets, field
  positions, reset values and timing counts.
  Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef FAULT_MGR_DEFS_SVH
`define FAULT_MGR_DEFS_SVH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define CLK_MHZ         100
`define BLANK_US        180
`define BLANK_CYC       (`BLANK_US * `CLK_MHZ)
`define BROWNOUT_MS     25
`define BROWNOUT_CYC    (`BROWNOUT_MS * 1000 * `CLK_MHZ + 1)
`define GND_OPEN_US     200
`define GND_OPEN_CYC    (`GND_OPEN_US * `CLK_MHZ)
`define OUT_SHORT_MS    90
`define OUT_SHORT_CYC   (`OUT_SHORT_MS * 1000 * `CLK_MHZ)
`define RECOVER_S       4
`define RECOVER_CYC     (`RECOVER_S * 1000000 * `CLK_MHZ)
`define SHORT_PERIODS   3'h4

// ----------------------------------------
// Foldback: begin-end span of 64 codes
// ----------------------------------------
`define FOLD_BEGIN_CODE 8'hc0
`define FOLD_END_CODE   8'h80
`define FOLD_HALF       8'h40

// ----------------------------------------
// Registers (byte offsets)
// ----------------------------------------
`define REG_CONTROL     4'h0
`define REG_STATUS      4'h4
`define REG_CAUSE       4'h8
`define REG_SETPOINT    4'hc
`define CTL_FORCE_OFF   0
`define CTL_FOLD_EN     1
`define CONTROL_RESET   2'h2
`define ST_SUPPLY_LOW   0
`define ST_LATCH_VAR    1
`define ST_DRIVE_EN     2
`define ST_LOW_POWER    3
`define ST_STATE_LSB    4
`define CAUSE_RESET     8'h00

// Cause bit positions
`define C_WINDING       0
`define C_OTP           1
`define C_EXT_OVP       2
`define C_OUT_SHORT     3
`define C_VCC_OVP       4
`define C_DIE           5
`define C_CS_IMP        6
`define C_GND_OPEN      7

`endif

//--- logic/fault_mgr_pkg.sv
/*
  Types of the LED driver fault manager.
  Assumes fault_mgr_defs.svh carries all numeric constants.
*/
package fault_mgr_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    WAIT_SUPPLY,
    START_BLANK,
    RUNNING,
    LATCHED_OFF,
    RECOVER_WAIT,
    BROWNED_OUT
  } state_t;

endpackage

//--- logic/hold_timer.sv
/*
  Saturating run-time counter: done rises once run has stood
  for limit consecutive cycles, and falls as soon as run drops.
  Assumes limit is at least one and stable while running.
*/
`timescale 1ns/10ps
module hold_timer (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic [31:0] limit,
  output logic             done
);

  logic [31:0] count;       // Cycles with run high
  logic [31:0] next_count;

  // ----------------------------------------
  // Next count, saturates at limit
  // ----------------------------------------
  always_comb begin
    if (!run) begin
      next_count = 32'h0;
    end else if (count >= limit) begin
      next_count = count;
    end else begin
      next_count = count + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0;
    end else begin
      count <= next_count;
    end
  end

  // Level, cleared with run
  assign done = run && (count >= limit);

endmodule

//--- logic/led_fault_manager.sv
/*
  Fault manager and protection sequencer of a primary-side LED driver:
  supply sequencing, start-up blanking, brown-out, thermal foldback and
  OFF mode, gating of the gate-drive request, latching or auto-recovery.
  Assumes comparator flags arrive asynchronously from analog blocks,
  while driveReq, pulse events, temperature code and dim setpoint come
  from logic on core_clk. Software reaches it over Avalon-MM.
*/
`timescale 1ns/10ps
`include "fault_mgr_defs.svh"

module led_fault_manager #(
  parameter int unsigned BLANK_CYCLES    = `BLANK_CYC,
  parameter int unsigned BROWNOUT_CYCLES = `BROWNOUT_CYC,
  parameter int unsigned GND_OPEN_CYCLES = `GND_OPEN_CYC,
  parameter int unsigned SHORT_CYCLES    = `OUT_SHORT_CYC,
  parameter int unsigned RECOVER_CYCLES  = `RECOVER_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Asynchronous comparator flags
  input  wire logic        supplyAboveStart,
  input  wire logic        supplyBelowStop,
  input  wire logic        supplyBelowClear,
  input  wire logic        supplyOverVolt,
  input  wire logic        lineBelowTrip,
  input  wire logic        lineAboveRelease,
  input  wire logic        tempOtpTrip,
  input  wire logic        tempOtpRelease,
  input  wire logic        external_overvoltage_fault,
  input  wire logic        dieHot,
  input  wire logic        dieCool,
  input  wire logic        csImpedanceLow,
  input  wire logic        groundOpen,
  input  wire logic        zero_cross_pin,
  input  wire logic        csOverStop,
  input  wire logic        latchVariantStrap,
  // Same-clock inputs
  input  wire logic        driveReq,
  input  wire logic        maxOnEnd,
  input  wire logic        periodEnd,
  input  wire logic [7:0]  temp_sense_pin,
  input  wire logic [9:0]  dimSetpoint,
  // Outputs
  output logic             driveOut,
  output logic [9:0]       setpoint,
  output logic             startupCurrent,
  output logic             supply_low_flag,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [15:0] rawFlags;   // Pin flags before crossing
  logic [15:0] flags;      // Pin flags on core_clk

  assign rawFlags = {latchVariantStrap, csOverStop, zero_cross_pin, groundOpen,
                     csImpedanceLow, dieCool, dieHot, external_overvoltage_fault,
                     tempOtpRelease, tempOtpTrip, lineAboveRelease, lineBelowTrip,
                     supplyOverVolt, supplyBelowClear, supplyBelowStop,
                     supplyAboveStart};

  sync_2ff #(.WIDTH(16)) flagSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async    (rawFlags),
    .synced   (flags)
  );

  logic vccStart, vccStop, vccClear, vccOvp, lineLow, lineOk;
  logic otpTrip, otpRelease, extOvp, dieOver, dieOk, csImpLow;
  logic gndOpen, zeroLow, csOver, strap;
  assign {strap, csOver, zeroLow, gndOpen, csImpLow, dieOk, dieOver, extOvp,
          otpRelease, otpTrip, lineOk, lineLow, vccOvp, vccClear, vccStop,
          vccStart} = flags;

  // ----------------------------------------
  // Slow state: flags, strap, counters
  // ----------------------------------------
  fault_mgr_pkg::state_t state;       // Sequencer state
  fault_mgr_pkg::state_t next_state;
  logic       supplyLow;              // Undervoltage flag
  logic       next_supplyLow;
  logic       otpHeld;                // Temp-pin overheat pending release
  logic       next_otpHeld;
  logic       dieHeld;                // Die overheat pending cool-down
  logic       next_dieHeld;
  logic       latchVariant;           // Captured variant strap
  logic       next_latchVariant;
  logic [1:0] strapWait;              // Lets strap pass the synchroniser
  logic [1:0] next_strapWait;
  logic [2:0] overPeriods;            // Consecutive over-current periods
  logic [2:0] next_overPeriods;
  logic       overSeen;               // Over-current in current period
  logic       next_overSeen;

  logic blankDone, brownDone, gndDone, shortDone, recoverDone;
  logic running;
  assign running = (state == fault_mgr_pkg::RUNNING);

  // Flag hysteresis, strap and period counting
  always_comb begin
    next_supplyLow = supplyLow;
    if (vccStop) begin
      next_supplyLow = 1'b1;
    end else if (vccStart) begin
      next_supplyLow = 1'b0;
    end
    next_otpHeld = otpHeld;
    if (otpTrip && running) begin
      next_otpHeld = 1'b1;
    end else if (otpRelease) begin
      next_otpHeld = 1'b0;
    end
    next_dieHeld = dieHeld;
    if (dieOver) begin
      next_dieHeld = 1'b1;
    end else if (dieOk) begin
      next_dieHeld = 1'b0;
    end
    next_strapWait    = strapWait;
    next_latchVariant = latchVariant;
    if (strapWait != 2'h3) begin
      next_strapWait = strapWait + 2'h1;
      if (strapWait == 2'h2) begin
        next_latchVariant = strap;
      end
    end
    next_overSeen    = overSeen;
    next_overPeriods = overPeriods;
    if (!running) begin
      next_overSeen    = 1'b0;
      next_overPeriods = 3'h0;
    end else if (periodEnd) begin
      next_overSeen    = 1'b0;
      // Sticks at the threshold while over-current persists; a period without over-current clears it
      if ((overSeen || csOver) && overPeriods != `SHORT_PERIODS) begin
        next_overPeriods = overPeriods + 3'h1;
      end else if (!(overSeen || csOver)) begin
        next_overPeriods = 3'h0;
      end
    end else if (csOver) begin
      next_overSeen = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      supplyLow    <= 1'b1;
      otpHeld      <= 1'b0;
      dieHeld      <= 1'b0;
      latchVariant <= 1'b0;
      strapWait    <= 2'h0;
      overSeen     <= 1'b0;
      overPeriods  <= 3'h0;
    end else begin
      supplyLow    <= next_supplyLow;
      otpHeld      <= next_otpHeld;
      dieHeld      <= next_dieHeld;
      latchVariant <= next_latchVariant;
      strapWait    <= next_strapWait;
      overSeen     <= next_overSeen;
      overPeriods  <= next_overPeriods;
    end
  end

  // ----------------------------------------
  // Timers, all on core_clk
  // ----------------------------------------
  hold_timer blankTimer (
    .core_clk (core_clk), .rstn (rstn),
    .run      (state == fault_mgr_pkg::START_BLANK),
    .limit    (BLANK_CYCLES), .done (blankDone));

  // Counts only while operating, so a low line at power-up is not brown-out
  hold_timer brownTimer (
    .core_clk (core_clk), .rstn (rstn),
    .run      (lineLow && (running || state == fault_mgr_pkg::START_BLANK)),
    .limit    (BROWNOUT_CYCLES), .done (brownDone));

  hold_timer gndTimer (
    .core_clk (core_clk), .rstn (rstn),
    .run      (gndOpen), .limit (GND_OPEN_CYCLES), .done (gndDone));

  hold_timer shortTimer (
    .core_clk (core_clk), .rstn (rstn),
    .run      (zeroLow && running), .limit (SHORT_CYCLES), .done (shortDone));

  hold_timer recoverTimer (
    .core_clk (core_clk), .rstn (rstn),
    .run      (state == fault_mgr_pkg::RECOVER_WAIT),
    .limit    (RECOVER_CYCLES), .done (recoverDone));

  // ----------------------------------------
  // Fault classification
  // ----------------------------------------
  logic       impCheck;     // Start-up or max on-time impedance check
  logic [7:0] causeNow;     // Fault events this cycle
  logic       latchFault;   // Fault of the latchable group
  logic       anyFault;

  assign impCheck = (state == fault_mgr_pkg::START_BLANK && blankDone)
                  || (running && maxOnEnd);
  always_comb begin
    causeNow                = 8'h00;
    causeNow[`C_WINDING]   = (overPeriods == `SHORT_PERIODS);
    causeNow[`C_OTP]       = otpTrip && running;
    causeNow[`C_EXT_OVP]   = extOvp;
    causeNow[`C_OUT_SHORT] = shortDone;
    causeNow[`C_VCC_OVP]   = vccOvp;
    causeNow[`C_DIE]       = dieOver;
    causeNow[`C_CS_IMP]    = impCheck && csImpLow;
    causeNow[`C_GND_OPEN]  = gndDone;
  end
  // Only winding short, temp-pin OTP, external OVP and output short may latch; supply OVP never
  assign latchFault = latchVariant && (causeNow[`C_WINDING] || causeNow[`C_OTP]
                      || causeNow[`C_EXT_OVP] || causeNow[`C_OUT_SHORT]);
  assign anyFault   = (causeNow != 8'h00);

  // ----------------------------------------
  // Registers written by software
  // ----------------------------------------
  logic [1:0] control;       // Force-off and foldback enable
  logic [1:0] next_control;
  logic [7:0] cause;         // Sticky fault causes, write one to clear
  logic [7:0] next_cause;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      fault_mgr_pkg::WAIT_SUPPLY: begin
        if (!supplyLow && vccStart && !control[`CTL_FORCE_OFF]) begin
          next_state = fault_mgr_pkg::START_BLANK;
        end
      end
      fault_mgr_pkg::START_BLANK, fault_mgr_pkg::RUNNING: begin
        if (supplyLow || control[`CTL_FORCE_OFF]) begin
          next_state = fault_mgr_pkg::WAIT_SUPPLY;
        end else if (latchFault) begin
          next_state = fault_mgr_pkg::LATCHED_OFF;
        end else if (anyFault) begin
          next_state = fault_mgr_pkg::RECOVER_WAIT;
        end else if (brownDone) begin
          next_state = fault_mgr_pkg::BROWNED_OUT;
        end else if (state == fault_mgr_pkg::START_BLANK && blankDone) begin
          next_state = fault_mgr_pkg::RUNNING;
        end
      end
      fault_mgr_pkg::LATCHED_OFF: begin
        if (vccClear) begin
          next_state = fault_mgr_pkg::WAIT_SUPPLY;
        end
      end
      fault_mgr_pkg::RECOVER_WAIT: begin
        if (recoverDone && vccStart && !dieHeld && !otpHeld) begin
          next_state = fault_mgr_pkg::START_BLANK;
        end
      end
      fault_mgr_pkg::BROWNED_OUT: begin
        // No supply cycling needed: restarts once line and supply agree
        if (lineOk && vccStart && !control[`CTL_FORCE_OFF]) begin
          next_state = fault_mgr_pkg::START_BLANK;
        end
      end
      default: begin
        next_state = fault_mgr_pkg::WAIT_SUPPLY;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= fault_mgr_pkg::WAIT_SUPPLY;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Foldback and outputs
  // ----------------------------------------
  // Scale in 1/128: 128 above begin level, 64 at or below end level
  function automatic logic [7:0] fold_factor(input logic [7:0] code);
    if (code >= `FOLD_BEGIN_CODE) begin
      fold_factor = 8'h80;
    end else if (code <= `FOLD_END_CODE) begin
      fold_factor = `FOLD_HALF;
    end else begin
      fold_factor = `FOLD_HALF + (code - `FOLD_END_CODE);
    end
  endfunction

  logic [7:0]  factor;
  logic [17:0] product;
  logic [9:0]  next_setpoint;
  logic        next_driveOut;

  always_comb begin
    factor        = control[`CTL_FOLD_EN] ? fold_factor(temp_sense_pin) : 8'h80;
    product       = dimSetpoint * factor;
    next_setpoint = product[16:7];
    next_driveOut = driveReq && running && !anyFault && !supplyLow;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      setpoint <= 10'h000;
      driveOut <= 1'b0;
    end else begin
      setpoint <= next_setpoint;
      driveOut <= next_driveOut;
    end
  end

  assign startupCurrent  = (state != fault_mgr_pkg::RUNNING)
                        && (state != fault_mgr_pkg::START_BLANK);
  assign supply_low_flag = supplyLow;

  // ----------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------
  logic        ack;          // High in the answer cycle
  logic        next_ack;
  logic [31:0] next_readdata;
  logic        doWrite;

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign doWrite         = avs_write && ack && avs_byteenable[0];

  always_comb begin
    next_ack      = (avs_read || avs_write) && !ack;
    next_readdata = avs_readdata;
    if (avs_read && !ack) begin
      case (avs_address)
        `REG_CONTROL:  next_readdata = {30'h0, control};
        `REG_STATUS:   next_readdata = {25'h0, state, startupCurrent,
                                        driveOut, latchVariant, supplyLow};
        `REG_CAUSE:    next_readdata = {24'h0, cause};
        `REG_SETPOINT: next_readdata = {22'h0, setpoint};
        default:       next_readdata = 32'h0;  // Unmapped reads zero
      endcase
    end
    next_control = control;
    if (doWrite && avs_address == `REG_CONTROL) begin
      next_control = avs_writedata[1:0];
    end
    // New events win over a clear in the same cycle
    next_cause = cause;
    if (doWrite && avs_address == `REG_CAUSE) begin
      next_cause = cause & ~avs_writedata[7:0];
    end
    next_cause = next_cause | causeNow;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0;
      control      <= `CONTROL_RESET;
      cause        <= `CAUSE_RESET;
    end else begin
      ack          <= next_ack;
      avs_readdata <= next_readdata;
      control      <= next_control;
      cause        <= next_cause;
    end
  end

endmodule

//--- logic/sync_2ff.sv
/*
  Two flip-flop synchroniser for a vector of independent level flags.
  Assumes each bit is a slow level; no multi-bit coherence is implied.
*/
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;  // Metastable stage, read only by synced

  // ----------------------------------------
  // Two stages
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

//--- verification/fault_front_model.sv
/*
  Model of the supply comparators and the switching modulator.
  Assumes the bench picks a coarse supply level, never a voltage.
*/
`timescale 1ns/10ps
module fault_front_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] vccLvl,
  output logic            supplyAboveStart,
  output logic            supplyBelowStop,
  output logic            supplyBelowClear,
  output logic            supplyOverVolt,
  output logic            driveReq,
  output logic            periodEnd
);
  logic [2:0] phase; // Position within one switching period
  // ----------------------------------------
  // Comparators: 0 clear, 1 stop, 2 between, 3 start, 4 overvoltage
  // ----------------------------------------
  assign supplyBelowClear = (vccLvl == 3'h0);
  assign supplyBelowStop  = (vccLvl <= 3'h1);
  assign supplyAboveStart = (vccLvl >= 3'h3);
  assign supplyOverVolt   = (vccLvl == 3'h4);
  // Modulator: fixed eight-cycle period, three cycles on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  assign driveReq  = (phase < 3'h3);
  assign periodEnd = (phase == 3'h7);
endmodule

//--- verification/led_fault_manager_assertions.sv
/*
  Port checker of the LED driver fault manager.
  Assumes it is bound to the top module from the bench top file.
*/
`timescale 1ns/10ps
module fault_mgr_checker (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       supplyAboveStart,
  input wire logic       supplyBelowStop,
  input wire logic       supplyOverVolt,
  input wire logic       dieHot,
  input wire logic       driveReq,
  input wire logic [7:0] temp_sense_pin,
  input wire logic [9:0] dimSetpoint,
  input wire logic       avs_read,
  input wire logic       avs_waitrequest,
  input wire logic       driveOut,
  input wire logic [9:0] setpoint,
  input wire logic       supply_low_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // A pulse never appears without a request one cycle earlier
  property p_gate; driveOut |-> $past(driveReq); endproperty
  // Four cycles cover the two-stage sync plus the flag register
  property p_low_set; supplyBelowStop [*4] |=> supply_low_flag; endproperty
  property p_low_hold;
    (!supplyAboveStart && !supplyBelowStop) [*4] |=> $stable(supply_low_flag);
  endproperty
  property p_set_full; rstn && temp_sense_pin >= 8'hc0 |=> setpoint == $past(dimSetpoint);
  endproperty
  property p_set_half; rstn && temp_sense_pin <= 8'h80 |=> setpoint == ($past(dimSetpoint) >> 1);
  endproperty
  property p_ack; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  property p_blank; $fell(supply_low_flag) |-> !driveOut [*8]; endproperty
  property p_die; dieHot [*5] |=> !driveOut; endproperty
  property p_ovp; supplyOverVolt [*5] |=> !driveOut; endproperty
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_gate: assert property (p_gate) else $error("drive without request");
  a_low_set: assert property (p_low_set) else $error("low flag missing");
  a_low_hold: assert property (p_low_hold) else $error("low flag moved");
  a_set_full: assert property (p_set_full) else $error("full setpoint wrong");
  a_set_half: assert property (p_set_half) else $error("half setpoint wrong");
  a_ack: assert property (p_ack) else $error("bus answer late");
  a_blank: assert property (p_blank) else $error("drive in blanking");
  a_die: assert property (p_die) else $error("drive while die hot");
  a_ovp: assert property (p_ovp) else $error("drive in overvoltage");
  c_blank: cover property ($fell(supply_low_flag));
  c_half: cover property (temp_sense_pin <= 8'h80);
  c_die: cover property (dieHot [*5]);
endmodule

//--- verification/led_fault_manager_test.sv
/*
  Self-checking bench of the LED driver fault manager.
  Assumes shortened timer parameters and the front model beside it.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin nFail++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module led_fault_manager_test;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic core_clk = 0, rstn = 0, lineBelowTrip = 0, lineAboveRelease = 1;
  logic tempOtpTrip = 0, tempOtpRelease = 1, external_overvoltage_fault = 0;
  logic dieHot = 0, dieCool = 1, latchVariantStrap = 0, maxOnEnd = 0;
  logic csImpedanceLow = 0, groundOpen = 0, zero_cross_pin = 0, csOverStop = 0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [2:0]  vccLvl = 3'h0; // Supply starts discharged
  logic [7:0]  temp_sense_pin = 8'hff;
  logic [9:0]  dimSetpoint = 10'h3ff, setpoint;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic supplyAboveStart, supplyBelowStop, supplyBelowClear, supplyOverVolt;
  logic driveReq, periodEnd, driveOut, startupCurrent, supply_low_flag, prev;
  int nFail = 0, samplesChecked = 0;
  always #5 core_clk = ~core_clk;
  fault_front_model front (.core_clk, .rstn, .vccLvl, .supplyAboveStart,
    .supplyBelowStop, .supplyBelowClear, .supplyOverVolt, .driveReq, .periodEnd);
  // Short timers keep the run brief
  led_fault_manager #(.BLANK_CYCLES(20), .BROWNOUT_CYCLES(50), .GND_OPEN_CYCLES(20),
    .SHORT_CYCLES(40), .RECOVER_CYCLES(60)) uut (.core_clk, .rstn, .supplyAboveStart,
    .supplyBelowStop, .supplyBelowClear, .supplyOverVolt, .lineBelowTrip,
    .lineAboveRelease, .tempOtpTrip, .tempOtpRelease, .external_overvoltage_fault,
    .dieHot, .dieCool, .csImpedanceLow, .groundOpen, .zero_cross_pin,
    .csOverStop, .latchVariantStrap, .driveReq, .maxOnEnd, .periodEnd,
    .temp_sense_pin, .dimSetpoint, .driveOut, .setpoint, .startupCurrent,
    .supply_low_flag, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One bus access; an idle edge follows so requests never merge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chkState(input logic [2:0] s);
    acc(1'b0, 4'h4, 32'h0);
    `CHK(d[6:4], s)
  endtask
  task automatic fold(input logic [7:0] c, input logic [9:0] dim, input logic [9:0] e);
    temp_sense_pin <= c;
    dimSetpoint <= dim;
    tick(3);
    `CHK(setpoint, e)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tStart();
    vccLvl <= 3'h3;
    tick(6);
    `CHK(supply_low_flag, 1'b0)
    repeat (12) begin @(posedge core_clk); `CHK(driveOut, 1'b0) end
    tick(20);
    chkState(3'h2);
    for (int i = 0; i < 8; i++) begin
      prev = driveReq;
      @(posedge core_clk);
      `CHK(driveOut, prev)
    end
  endtask
  task automatic tFold();
    fold(8'hc0, 10'h200, 10'h200);
    fold(8'ha0, 10'h200, 10'h180);
    fold(8'h60, 10'h200, 10'h100);
    fold(8'h80, 10'h100, 10'h080);
    temp_sense_pin <= 8'hff;
  endtask
  // Short line dip is ignored, a long one stops the block
  task automatic tBrown();
    lineAboveRelease <= 1'b0;
    lineBelowTrip <= 1'b1;
    tick(30);
    lineBelowTrip <= 1'b0;
    chkState(3'h2);
    lineBelowTrip <= 1'b1;
    tick(60);
    chkState(3'h5);
    `CHK({startupCurrent, supply_low_flag}, 2'h2)
    lineBelowTrip <= 1'b0;
    lineAboveRelease <= 1'b1;
    tick(5);
    chkState(3'h1);
    tick(25);
  endtask
  task automatic tAuto();
    dieHot <= 1'b1;
    dieCool <= 1'b0;
    tick(6);
    `CHK(driveOut, 1'b0)
    chkState(3'h4);
    dieHot <= 1'b0;
    tick(70);
    chkState(3'h4);
    dieCool <= 1'b1;
    tick(5);
    chkState(3'h1);
    acc(1'b0, 4'h8, 32'h0);
    `CHK(d[5], 1'b1)
    acc(1'b1, 4'h8, 32'hff);
    acc(1'b0, 4'h8, 32'h0);
    `CHK(d[7:0], 8'h00)
    acc(1'b0, 4'h6, 32'h0);
    `CHK(d, 32'h0)
    tick(25);
    vccLvl <= 3'h4;
    tick(6);
    vccLvl <= 3'h3;
    tick(30);
    chkState(3'h4);
    tick(30);
    chkState(3'h1);
    tick(25);
  endtask
  // Pin faults in the auto variant
  task automatic tPins();
    groundOpen <= 1'b1;
    tick(10);
    chkState(3'h2);
    tick(12);
    chkState(3'h4);
    groundOpen <= 1'b0;
    csImpedanceLow <= 1'b1;
    tick(90);
    chkState(3'h4);
    csImpedanceLow <= 1'b0;
    tick(90);
    csImpedanceLow <= 1'b1;
    tick(3);
    chkState(3'h2);
    maxOnEnd <= 1'b1;
    tick(1);
    maxOnEnd <= 1'b0;
    tick(3);
    chkState(3'h4);
    csImpedanceLow <= 1'b0;
    tick(80);
    zero_cross_pin <= 1'b1;
    tick(30);
    chkState(3'h2);
    tick(20);
    chkState(3'h4);
    zero_cross_pin <= 1'b0;
    tick(75);
    csOverStop <= 1'b1;
    tick(40);
    chkState(3'h4);
    csOverStop <= 1'b0;
  endtask
  task automatic tLatch();
    latchVariantStrap <= 1'b1;
    rstn <= 1'b0;
    tick(3);
    rstn <= 1'b1;
    vccLvl <= 3'h0;
    tick(6);
    vccLvl <= 3'h2;
    tick(6);
    `CHK(supply_low_flag, 1'b1)
    vccLvl <= 3'h3;
    tick(40);
    acc(1'b0, 4'h4, 32'h0);
    `CHK(d[1], 1'b1)
    tempOtpTrip <= 1'b1;
    tempOtpRelease <= 1'b0;
    tick(6);
    chkState(3'h3);
    tempOtpTrip <= 1'b0;
    tempOtpRelease <= 1'b1;
    tick(80);
    chkState(3'h3);
    vccLvl <= 3'h0;
    tick(6);
    vccLvl <= 3'h3;
    tick(40);
    chkState(3'h2);
    external_overvoltage_fault <= 1'b1;
    tick(6);
    chkState(3'h3);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    tick(3);
    rstn <= 1'b1;
    tick(2);
    tStart();
    tFold();
    tBrown();
    tAuto();
    tPins();
    tLatch();
    summarize();
  end
  initial begin
    tick(3000);
    nFail++;
    summarize();
  end
endmodule
bind led_fault_manager fault_mgr_checker chk (.core_clk, .rstn, .supplyAboveStart,
  .supplyBelowStop, .supplyOverVolt, .dieHot, .driveReq, .temp_sense_pin, .dimSetpoint,
  .avs_read, .avs_waitrequest, .driveOut, .setpoint, .supply_low_flag);
